// ==== opc_defines.svh ====
// Purpose: register offsets, field codes and timing constants
// Assumes: byte addresses on a 32-bit APB bus
// Notes:   definitions only
`ifndef OPC_DEFINES_SVH
`define OPC_DEFINES_SVH
`define OPC_A_WRPROT     12'h000
`define OPC_A_RDPROT     12'h004
`define OPC_A_STATUS     12'h008
`define OPC_A_PIDX       12'h00c
`define OPC_A_PDATA      12'h010
`define OPC_A_INFO       12'h014
`define OPC_A_COPY_SEL   12'h1b0
`define OPC_SEL_IDLE     16'h0000
`define OPC_SEL_READ     16'h0001
`define OPC_SEL_COPY     16'h0002
`define OPC_SEL_VERIFY   16'h0003
`define OPC_SEL_CAP      16'h0004
`define OPC_SEL_VER      16'h0005
`define OPC_WRPROT_RST   16'h0001
`define OPC_WRPROT_ALL   16'h0004
`define OPC_RDPROT_RST   16'h0000
`define OPC_RDPROT_OK    16'h0001
`define OPC_IDX_SEL      8'd176
`define OPC_IDX_RDPROT   8'd177
`define OPC_IDX_FAULTS   8'd178
`define OPC_IDX_FWVER    8'd179
`define OPC_IDX_HOLDF    8'd0
`define OPC_LCAP_FIRST   8'd170
`define OPC_LCAP_LAST    8'd175
`define OPC_RUNLOCK_LAST 8'd79
`define OPC_HOLD_MS      1000
`define OPC_CLK_KHZ      125000
`define OPC_HOLD_CYCLES  (`OPC_HOLD_MS * `OPC_CLK_KHZ)
`endif

// ==== opc_keypad.sv ====
// Purpose: operator keypad model at the far side of the panel
// Assumes: one key pulse of one cycle, then a quiet gap
// Notes:   codes 0 mode, 1 increment, 2 decrement, 3 enter
`timescale 1ns/1ps
module opc_keypad (
  input  wire logic pclk,
  output logic      key_mode,
  output logic      key_inc,
  output logic      key_dec,
  output logic      key_enter
);
  initial {key_mode, key_inc, key_dec, key_enter} = 4'h0;
  // the operator steps items with mode before reasserting run
  task automatic press(input int k, input int n);
    repeat (n) begin
      @(posedge pclk);
      {key_mode, key_inc, key_dec, key_enter} <= 4'h8 >> k;
      @(posedge pclk);
      {key_mode, key_inc, key_dec, key_enter} <= 4'h0;
      repeat (4) @(posedge pclk);
    end
  endtask
endmodule

// ==== opc_panel.sv ====
// Purpose: operator panel keypad logic and parameter copy/verify engine
// Assumes: key inputs are one-cycle pulses synchronous to pclk
// Notes:   parameter set and detachable store are local arrays
//
// Summary of operation
// - direction item shows direction; increment or decrement toggles it now
// - direction may change whether stopped or running
// - local/remote toggles only while stopped; value always shown
// - terminal-assigned local/remote follows the terminal, keypad ignored
// - run commands are ignored while local/remote item is shown
// - re-enable run: drop run, reach green item, then assert run again
// - program mode: keys pick number, enter shows data, edits flash
// - enter stores edit, display steady, back to number after 1 s
// - mode during editing discards the edit and shows the number
// - run-locked parameters keep their data on keys while running
// - selector at 0x1b0 takes idle, read, copy, verify, capacity, version
// - copy or write is refused while the drive runs
// - copy needs equal supply class and control mode
// - copy skips selector, read-prohibit, fault log, version, held freq
// - capacity-dependent parameters skipped when capacities differ
// - large-capacity functions not copied across capacities
// - store holds all parameters plus capacity and version
// - selector writes rejected unless write-prohibit selector is 4
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "opc_defines.svh"
module opc_panel #(
  parameter int NPARAM      = 180,
  parameter int HOLD_CYCLES = `OPC_HOLD_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              key_mode,
  input  wire logic              key_inc,
  input  wire logic              key_dec,
  input  wire logic              key_enter,
  input  wire logic              run_cmd,
  input  wire logic              drive_running,
  input  wire logic              lr_on_terminal,
  input  wire logic              lr_terminal_remote,
  input  wire logic [1:0]        drive_supply,
  input  wire logic              drive_vector,
  input  wire logic [7:0]        drive_capacity,
  input  wire logic [7:0]        drive_version,
  input  wire logic [15:0]       freq_reference,
  output opc_pkg::opc_item_t     disp_item,
  output logic      [15:0]       disp_value,
  output logic                   disp_flash,
  output logic                   dir_reverse,
  output logic                   remote_sel,
  output logic                   run_accept,
  output logic                   copy_busy,
  output logic                   copy_error
);
  import opc_pkg::*;

  logic [15:0] param_q [NPARAM];
  logic [15:0] store_q [NPARAM];
  logic [7:0]  st_cap_q;
  logic [7:0]  st_ver_q;
  logic [1:0]  st_sup_q;
  logic        st_vec_q;
  logic        st_valid_q;

  opc_item_t   item_q;
  opc_gate_t   gate_q;
  opc_cp_t     cp_q;
  logic [7:0]  num_q;
  logic [15:0] edit_q;
  logic        flash_q;
  logic [31:0] hold_q;
  logic        dir_q;
  logic        remote_q;
  logic [15:0] wrprot_q;
  logic [15:0] rdprot_q;
  logic [15:0] sel_q;
  logic [7:0]  pidx_q;
  logic [7:0]  cp_idx_q;
  logic        err_q;
  logic        mism_q;
  logic [15:0] info_q;
  logic [15:0] disp_d;

  logic        apb_wr;
  logic        apb_rd;
  logic        sel_wr;
  logic        sel_ok;
  logic        key_store;
  logic        pd_wr;
  logic        cp_last;
  logic        cap_diff;
  logic        id_ok;

  function automatic logic excluded(input logic [7:0] i);
    excluded = (i == `OPC_IDX_SEL) || (i == `OPC_IDX_RDPROT) ||
               (i == `OPC_IDX_FAULTS) || (i == `OPC_IDX_FWVER) ||
               (i == `OPC_IDX_HOLDF);
  endfunction

  function automatic logic cap_dep(input logic [7:0] i);
    cap_dep = (i >= 8'd11 && i <= 8'd17) || (i == 8'd36) ||
              (i == 8'd80) || (i >= 8'd105 && i <= 8'd110) ||
              (i == 8'd140) || (i == 8'd158) ||
              (i >= `OPC_LCAP_FIRST && i <= `OPC_LCAP_LAST);
  endfunction

  function automatic logic skip(input logic [7:0] i, input logic cd);
    skip = excluded(i) || (cd && cap_dep(i));
  endfunction

  localparam logic [7:0] LAST_IDX = 8'(NPARAM - 1);

  assign apb_wr    = psel && penable && pready && pwrite;
  assign apb_rd    = psel && penable && pready && !pwrite;
  assign sel_wr    = apb_wr && (paddr == `OPC_A_COPY_SEL);
  assign sel_ok    = (wrprot_q == `OPC_WRPROT_ALL);
  assign pd_wr     = apb_wr && (paddr == `OPC_A_PDATA) && !pslverr;
  assign key_store = (item_q == ITEM_DATA) && key_enter && flash_q;
  assign cp_last   = (cp_idx_q == LAST_IDX);
  assign cap_diff  = (st_cap_q != drive_capacity);
  assign id_ok     = st_valid_q && (st_sup_q == drive_supply) &&
                     (st_vec_q == drive_vector);

  // apb slave: one setup cycle, answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= 1'b0;
      if (psel && !penable && !pready) begin
        prdata <= 32'h0000_0000;
        unique case (paddr)
          `OPC_A_WRPROT:   prdata <= {16'h0000, wrprot_q};
          `OPC_A_RDPROT:   prdata <= {16'h0000, rdprot_q};
          `OPC_A_STATUS:   prdata <= {24'h00_0000, st_valid_q, mism_q,
                                      err_q, copy_busy, run_accept,
                                      remote_q, dir_q, drive_running};
          `OPC_A_PIDX:     prdata <= {24'h00_0000, pidx_q};
          `OPC_A_PDATA:    prdata <= {16'h0000, param_q[pidx_q]};
          `OPC_A_INFO:     prdata <= {16'h0000, info_q};
          `OPC_A_COPY_SEL: prdata <= {16'h0000, sel_q};
          default:         pslverr <= 1'b1;
        endcase
        if (pwrite && (paddr == `OPC_A_COPY_SEL) &&
            (wrprot_q != `OPC_WRPROT_ALL))
          pslverr <= 1'b1;
        if (pwrite && (paddr == `OPC_A_PDATA) && drive_running)
          pslverr <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrprot_q <= `OPC_WRPROT_RST;
      rdprot_q <= `OPC_RDPROT_RST;
      pidx_q   <= 8'h00;
    end else if (apb_wr) begin
      if (paddr == `OPC_A_WRPROT)
        wrprot_q <= pwdata[15:0];
      if (paddr == `OPC_A_RDPROT)
        rdprot_q <= pwdata[15:0];
      if (paddr == `OPC_A_PIDX && pwdata[7:0] <= LAST_IDX)
        pidx_q <= pwdata[7:0];
    end
  end

  // parameter set: copy engine, keypad store, bus write
  always_ff @(posedge pclk) begin
    if (cp_q == CP_COPY && !skip(cp_idx_q, cap_diff))
      param_q[cp_idx_q] <= store_q[cp_idx_q];
    else if (key_store)
      param_q[num_q] <= edit_q;
    else if (pd_wr)
      param_q[pidx_q] <= pwdata[15:0];
  end

  // detachable store keeps every parameter plus drive identity
  always_ff @(posedge pclk) begin
    if (cp_q == CP_READ)
      store_q[cp_idx_q] <= param_q[cp_idx_q];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_cap_q   <= 8'h00;
      st_ver_q   <= 8'h00;
      st_sup_q   <= 2'b00;
      st_vec_q   <= 1'b0;
      st_valid_q <= 1'b0;
    end else if (cp_q == CP_READ && cp_last) begin
      st_cap_q   <= drive_capacity;
      st_ver_q   <= drive_version;
      st_sup_q   <= drive_supply;
      st_vec_q   <= drive_vector;
      st_valid_q <= 1'b1;
    end
  end

  // copy/verify engine, one parameter per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_q     <= CP_IDLE;
      cp_idx_q <= 8'h00;
      sel_q    <= `OPC_SEL_IDLE;
      err_q    <= 1'b0;
      mism_q   <= 1'b0;
      info_q   <= 16'h0000;
    end else if (cp_q != CP_IDLE) begin
      cp_idx_q <= cp_idx_q + 8'd1;
      if (cp_q == CP_VERIFY && !skip(cp_idx_q, cap_diff) &&
          store_q[cp_idx_q] != param_q[cp_idx_q])
        mism_q <= 1'b1;
      if (cp_last) begin
        cp_q  <= CP_IDLE;
        sel_q <= `OPC_SEL_IDLE;
      end
    end else if (sel_wr && sel_ok) begin
      sel_q    <= pwdata[15:0];
      cp_idx_q <= 8'h00;
      err_q    <= 1'b0;
      unique case (pwdata[15:0])
        `OPC_SEL_READ: begin
          if (drive_running || rdprot_q != `OPC_RDPROT_OK)
            err_q <= 1'b1;
          else
            cp_q <= CP_READ;
        end
        `OPC_SEL_COPY: begin
          if (drive_running || !id_ok)
            err_q <= 1'b1;
          else
            cp_q <= CP_COPY;
        end
        `OPC_SEL_VERIFY: begin
          mism_q <= 1'b0;
          if (!id_ok)
            err_q <= 1'b1;
          else
            cp_q <= CP_VERIFY;
        end
        `OPC_SEL_CAP:  info_q <= {8'h00, drive_capacity};
        `OPC_SEL_VER:  info_q <= {8'h00, drive_version};
        `OPC_SEL_IDLE: info_q <= 16'h0000;
        default: begin
          err_q <= 1'b1;
          sel_q <= `OPC_SEL_IDLE;
        end
      endcase
    end
  end

  // display item and program-mode editing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      item_q  <= ITEM_FREQUENCY_REFERENCE_INDICATOR;
      num_q   <= 8'h01;
      edit_q  <= 16'h0000;
      flash_q <= 1'b0;
      hold_q  <= 32'h0000_0000;
    end else begin
      unique case (item_q)
        ITEM_FREQUENCY_REFERENCE_INDICATOR: if (key_mode) item_q <= ITEM_DIR;
        ITEM_DIR:  if (key_mode) item_q <= ITEM_LR;
        ITEM_LR:   if (key_mode) item_q <= ITEM_NUM;
        ITEM_NUM: begin
          if (key_mode)
            item_q <= ITEM_FREQUENCY_REFERENCE_INDICATOR;
          else if (key_enter) begin
            item_q  <= ITEM_DATA;
            edit_q  <= param_q[num_q];
            flash_q <= 1'b0;
          end else if (key_inc)
            num_q <= (num_q == LAST_IDX) ? 8'h00 : num_q + 8'd1;
          else if (key_dec)
            num_q <= (num_q == 8'h00) ? LAST_IDX : num_q - 8'd1;
        end
        ITEM_DATA: begin
          if (key_mode) begin
            item_q  <= ITEM_NUM;
            flash_q <= 1'b0;
          end else if (key_enter) begin
            item_q  <= ITEM_HOLD;
            flash_q <= 1'b0;
            hold_q  <= 32'(HOLD_CYCLES - 1);
          end else if ((key_inc || key_dec) &&
                       !(drive_running && num_q <= `OPC_RUNLOCK_LAST)) begin
            edit_q  <= key_inc ? edit_q + 16'd1 : edit_q - 16'd1;
            flash_q <= 1'b1;
          end
        end
        ITEM_HOLD: begin
          if (hold_q == 32'h0000_0000)
            item_q <= ITEM_NUM;
          else
            hold_q <= hold_q - 32'd1;
        end
        default: item_q <= ITEM_FREQUENCY_REFERENCE_INDICATOR;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dir_q <= 1'b0;
    else if (item_q == ITEM_DIR && (key_inc || key_dec))
      dir_q <= !dir_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      remote_q <= 1'b1;
    else if (lr_on_terminal)
      remote_q <= lr_terminal_remote;
    else if (item_q == ITEM_LR && (key_inc || key_dec) && !drive_running)
      remote_q <= !remote_q;
  end

  // run gate: blocked on local/remote item until drop, green item, reassert
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gate_q <= RG_OPEN;
    else begin
      unique case (gate_q)
        RG_OPEN:  if (item_q == ITEM_LR && run_cmd) gate_q <= RG_BLOCK;
        RG_BLOCK: if (!run_cmd) gate_q <= RG_WAIT;
        RG_WAIT: begin
          if (run_cmd)
            gate_q <= RG_BLOCK;
          else if (item_q == ITEM_FREQUENCY_REFERENCE_INDICATOR)
            gate_q <= RG_OPEN;
        end
        default: gate_q <= RG_OPEN;
      endcase
    end
  end

  always_comb begin
    disp_d = 16'h0000;
    unique case (item_q)
      ITEM_FREQUENCY_REFERENCE_INDICATOR: disp_d = freq_reference;
      ITEM_DIR:  disp_d = {15'h0000, dir_q};
      ITEM_LR:   disp_d = {15'h0000, remote_q};
      ITEM_NUM:  disp_d = {8'h00, num_q};
      ITEM_DATA: disp_d = edit_q;
      ITEM_HOLD: disp_d = edit_q;
      default:   disp_d = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_item   <= ITEM_FREQUENCY_REFERENCE_INDICATOR;
      disp_value  <= 16'h0000;
      disp_flash  <= 1'b0;
      dir_reverse <= 1'b0;
      remote_sel  <= 1'b1;
      run_accept  <= 1'b0;
      copy_busy   <= 1'b0;
      copy_error  <= 1'b0;
    end else begin
      disp_item   <= item_q;
      disp_value  <= disp_d;
      disp_flash  <= flash_q;
      dir_reverse <= dir_q;
      remote_sel  <= remote_q;
      run_accept  <= run_cmd && gate_q == RG_OPEN &&
                     item_q != ITEM_LR;
      copy_busy   <= (cp_q != CP_IDLE);
      copy_error  <= err_q;
    end
  end
endmodule

// ==== opc_panel_props.sv ====
// Purpose: port checker for the operator panel block
// Assumes: key inputs are one-cycle pulses spaced apart
// Notes:   attached to every opc_panel instance by bind
`timescale 1ns/1ps
`include "opc_defines.svh"
module opc_panel_props #(
  parameter int HOLD_CYCLES = 20
) (
  input logic                pclk,
  input logic                presetn,
  input logic                psel,
  input logic                penable,
  input logic                pwrite,
  input logic [11:0]         paddr,
  input logic                pready,
  input logic                pslverr,
  input logic                key_mode,
  input logic                key_inc,
  input logic                key_dec,
  input logic                key_enter,
  input logic                run_cmd,
  input logic                drive_running,
  input logic                lr_on_terminal,
  input logic                lr_terminal_remote,
  input opc_pkg::opc_item_t  disp_item,
  input logic                disp_flash,
  input logic                dir_reverse,
  input logic                remote_sel,
  input logic                run_accept
);
  import opc_pkg::*;
  logic [31:0] hold_n;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // counts the cycles for which the hold item is shown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_n <= 32'h0000_0000;
    else if (disp_item == ITEM_HOLD)
      hold_n <= hold_n + 32'd1;
    else
      hold_n <= 32'h0000_0000;
  end
  property p_dir;
    disp_item == ITEM_DIR && (key_inc || key_dec) && !$past(key_mode)
      |-> ##2 dir_reverse != $past(dir_reverse);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not toggled");
  property p_lr_run;
    !lr_on_terminal && drive_running |-> ##2 $stable(remote_sel);
  endproperty
  a_lr_run: assert property (p_lr_run) else $error("source changed");
  property p_lr_term;
    lr_on_terminal [*3] |-> remote_sel == $past(lr_terminal_remote, 2);
  endproperty
  a_lr_term: assert property (p_lr_term) else $error("terminal lost");
  property p_run_lr;
    disp_item == ITEM_LR |-> !run_accept;
  endproperty
  a_run_lr: assert property (p_run_lr) else $error("run in lr item");
  property p_run_gate;
    disp_item == ITEM_LR && run_cmd && !$past(key_mode) ##1 run_cmd [*4]
      |-> !run_accept;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("gate open");
  property p_store;
    disp_flash && key_enter |-> ##2 disp_item == ITEM_HOLD && !disp_flash;
  endproperty
  a_store: assert property (p_store) else $error("store not shown");
  property p_hold;
    (disp_item == ITEM_HOLD |-> hold_n < 32'(HOLD_CYCLES)) and
    ($past(disp_item) == ITEM_HOLD && disp_item != ITEM_HOLD
      |-> disp_item == ITEM_NUM && hold_n == 32'(HOLD_CYCLES));
  endproperty
  a_hold: assert property (p_hold) else $error("hold length wrong");
  property p_cancel;
    disp_item == ITEM_DATA && disp_flash && key_mode
      |-> ##2 disp_item == ITEM_NUM && !disp_flash;
  endproperty
  a_cancel: assert property (p_cancel) else $error("edit not dropped");
  property p_wr_run;
    psel && penable && pwrite && paddr == `OPC_A_PDATA && $past(drive_running)
      |-> pready && pslverr;
  endproperty
  a_wr_run: assert property (p_wr_run) else $error("run write taken");
endmodule
bind opc_panel opc_panel_props #(.HOLD_CYCLES(HOLD_CYCLES)) opc_panel_props_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .key_mode, .key_inc, .key_dec, .key_enter, .run_cmd, .drive_running,
  .lr_on_terminal, .lr_terminal_remote, .disp_item, .disp_flash,
  .dir_reverse, .remote_sel, .run_accept
);

// ==== opc_pkg.sv ====
// Purpose: shared types of the operator panel block
// Assumes: nothing
// Notes:   constants live in opc_defines.svh
package opc_pkg;
  typedef enum logic [2:0] {
    ITEM_FREQUENCY_REFERENCE_INDICATOR, ITEM_DIR, ITEM_LR, ITEM_NUM, ITEM_DATA, ITEM_HOLD
  } opc_item_t;
  typedef enum logic [1:0] {RG_OPEN, RG_BLOCK, RG_WAIT} opc_gate_t;
  typedef enum logic [1:0] {CP_IDLE, CP_READ, CP_COPY, CP_VERIFY} opc_cp_t;
endpackage

// ==== tb_operator_panel_param_copy.sv ====
// Purpose: self-checking bench of the operator panel block
// Assumes: zero-wait APB slave, hold time shortened to 20 cycles
// Notes:   keypad comes from the partner model
`timescale 1ns/1ps
`include "opc_defines.svh"
module tb_operator_panel_param_copy;
  import opc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, key_mode, key_inc, key_dec, key_enter;
  logic        run_cmd = 0, drive_running = 0, lr_on_terminal = 0;
  logic        lr_terminal_remote = 0, drive_vector = 0;
  logic [1:0]  drive_supply = 0;
  logic [7:0]  drive_capacity = 8'h11, drive_version = 8'h21;
  logic [15:0] disp_value, freq_reference = 16'h1234;
  opc_item_t   disp_item;
  logic        disp_flash, dir_reverse, remote_sel, run_accept;
  logic        copy_busy, copy_error;
  int          n_fail = 0, n_compared = 0;
  opc_panel #(.HOLD_CYCLES(20)) opc_panel_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .key_mode, .key_inc, .key_dec, .key_enter, .run_cmd, .drive_running,
    .lr_on_terminal, .lr_terminal_remote, .drive_supply, .drive_vector,
    .drive_capacity, .drive_version, .freq_reference, .disp_item,
    .disp_value, .disp_flash, .dir_reverse, .remote_sel, .run_accept,
    .copy_busy, .copy_error);
  opc_keypad opc_keypad_i (.pclk, .key_mode, .key_inc, .key_dec, .key_enter);
  always #4 pclk = ~pclk;
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic kp(input int k, input int n = 1);
    opc_keypad_i.press(k, n);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, logic x);
    logic [31:0] r;
    logic        e;
    apb(1, a, d, r, e);
    chk(e === x, "write response");
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
    input logic xe = 0, input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] r;
    logic        e;
    apb(0, a, 0, r, e);
    chk((r & m) === x && e === xe, "read value");
  endtask
  task automatic pset(input logic [7:0] i, input logic [15:0] v);
    wr(`OPC_A_PIDX, i, 0);
    wr(`OPC_A_PDATA, v, 0);
  endtask
  task automatic pget(input logic [7:0] i, input logic [15:0] v);
    wr(`OPC_A_PIDX, i, 0);
    rd(`OPC_A_PDATA, v);
  endtask
  task automatic sel(input logic [15:0] c);
    wr(`OPC_A_COPY_SEL, c, 0);
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 400 && copy_busy !== 1'b0; i++) @(posedge pclk);
    chk(copy_busy === 1'b0, "engine stuck");
  endtask
  task automatic clobber;
    pset(0, 9);
    pset(11, 9);
    pset(20, 9);
    pset(170, 9);
  endtask
  task automatic t_regs;
    rd(`OPC_A_WRPROT, `OPC_WRPROT_RST);
    rd(`OPC_A_RDPROT, `OPC_RDPROT_RST);
    rd(`OPC_A_COPY_SEL, `OPC_SEL_IDLE);
    rd(12'h020, 0, 1);
    wr(`OPC_A_COPY_SEL, `OPC_SEL_READ, 1);
    $display("test regs done");
  endtask
  task automatic t_dir;
    chk(disp_value === 16'h1234, "frequency_reference_indicator shown");
    kp(0);
    chk(disp_item === ITEM_DIR, "dir item");
    kp(1);
    chk(dir_reverse === 1'b1 && disp_value[0] === 1'b1, "reverse");
    drive_running <= 1;
    kp(2);
    chk(dir_reverse === 1'b0, "dir while running");
    drive_running <= 0;
    $display("test dir done");
  endtask
  task automatic t_lr;
    kp(0);
    drive_running <= 1;
    kp(1);
    chk(remote_sel === 1'b1 && disp_item === ITEM_LR, "lr running");
    drive_running <= 0;
    kp(1);
    chk(remote_sel === 1'b0 && disp_value[0] === 1'b0, "lr stopped");
    lr_on_terminal <= 1;
    lr_terminal_remote <= 1;
    kp(1);
    chk(remote_sel === 1'b1, "lr terminal");
    lr_on_terminal <= 0;
    run_cmd <= 1;
    repeat (4) @(posedge pclk);
    chk(run_accept === 1'b0, "run in lr");
    kp(0, 2);
    chk(run_accept === 1'b0, "run still held");
    run_cmd <= 0;
    repeat (4) @(posedge pclk);
    run_cmd <= 1;
    repeat (4) @(posedge pclk);
    chk(run_accept === 1'b1, "run reasserted");
    run_cmd <= 0;
    $display("test lr done");
  endtask
  task automatic t_param;
    pset(1, 5);
    kp(0, 3);
    chk(disp_item === ITEM_NUM && disp_value === 16'h0001, "num");
    kp(3);
    chk(disp_item === ITEM_DATA && disp_value === 16'h0005, "data");
    kp(1);
    chk(disp_flash === 1'b1 && disp_value === 16'h0006, "edit");
    kp(3);
    chk(disp_item === ITEM_HOLD && disp_flash === 1'b0, "stored");
    repeat (30) @(posedge pclk);
    chk(disp_item === ITEM_NUM, "back to num");
    rd(`OPC_A_PDATA, 6);
    kp(3);
    kp(1);
    kp(0);
    chk(disp_item === ITEM_NUM, "cancel");
    rd(`OPC_A_PDATA, 6);
    drive_running <= 1;
    kp(3);
    kp(1);
    chk(disp_value === 16'h0006 && disp_flash === 1'b0, "locked");
    wr(`OPC_A_PDATA, 9, 1);
    kp(0, 2);
    drive_running <= 0;
    $display("test param done");
  endtask
  task automatic t_copy;
    wr(`OPC_A_WRPROT, `OPC_WRPROT_ALL, 0);
    sel(`OPC_SEL_READ);
    chk(copy_error === 1'b1, "read prohibited");
    wr(`OPC_A_RDPROT, `OPC_RDPROT_OK, 0);
    pset(0, 1);
    pset(11, 2);
    pset(20, 3);
    pset(170, 4);
    sel(`OPC_SEL_READ);
    chk(copy_error === 1'b0, "read ok");
    rd(`OPC_A_COPY_SEL, `OPC_SEL_IDLE);
    clobber;
    drive_running <= 1;
    sel(`OPC_SEL_COPY);
    chk(copy_error === 1'b1, "copy running");
    drive_running <= 0;
    drive_supply <= 1;
    sel(`OPC_SEL_COPY);
    chk(copy_error === 1'b1, "supply mismatch");
    drive_supply <= 0;
    drive_vector <= 1;
    sel(`OPC_SEL_COPY);
    chk(copy_error === 1'b1, "mode mismatch");
    drive_vector <= 0;
    pget(20, 9);
    sel(`OPC_SEL_COPY);
    pget(0, 9);
    pget(11, 2);
    pget(20, 3);
    pget(170, 4);
    pset(0, 1);
    sel(`OPC_SEL_VERIFY);
    rd(`OPC_A_STATUS, 0, 0, 32'h0000_0060);
    clobber;
    sel(`OPC_SEL_VERIFY);
    rd(`OPC_A_STATUS, 32'h0000_0040, 0, 32'h0000_0060);
    drive_capacity <= 8'h33;
    sel(`OPC_SEL_COPY);
    pget(11, 9);
    pget(170, 9);
    pget(20, 3);
    sel(`OPC_SEL_CAP);
    rd(`OPC_A_INFO, 32'h0000_0033, 0, 32'h0000_00ff);
    sel(`OPC_SEL_VER);
    rd(`OPC_A_INFO, 32'h0000_0021, 0, 32'h0000_00ff);
    sel(16'h0006);
    chk(copy_error === 1'b1, "bad code");
    $display("test copy done");
  endtask
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_dir;
    t_lr;
    t_param;
    t_copy;
    give_verdict;
  end
  initial begin
    #400000;
    n_fail++;
    give_verdict;
  end
endmodule
